// ===== hw/usage_monitor_pkg.sv
/*
  Shared constants for the usage monitor status registers.
  Assumes a 4 KB feature frame per security space, word aligned.
*/
package usage_monitor_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] OFF_OVF_BITMAP = 12'h858;
  localparam logic [11:0] OFF_BW_COUNT = 12'h860;
  localparam int NOT_READY_POS = 31;
  localparam int VALUE_W = 31;
  localparam int GROUP_W = 32;
  localparam int SEL_W = 16;
  localparam logic [15:0] GROUP_MASK = 16'hffe0;
  localparam int NUM_SPACES = 4;
  typedef logic [1:0] space_t;
  localparam space_t SPACE_SECURE = 2'h0;
  localparam space_t SPACE_NONSECURE = 2'h1;
  localparam space_t SPACE_ROOT = 2'h2;
  localparam space_t SPACE_REALM = 2'h3;
  localparam logic RESET_NOT_READY = 1'b1;
  localparam logic RESET_OVF = 1'b0;
  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;
endpackage : usage_monitor_pkg

// ===== hw/usage_monitor_status_regs.sv
/*
  Overflow bitmap and bandwidth usage count registers, one copy per space.
  Assumes a one-cycle request strobe from the frame decoder, selection
  registers, filter matching and storage monitors outside, all on clk.
*/
`timescale 1ns/100ps
module usage_monitor_status_regs #(
  parameter int INST_W = 1,
  parameter int MON_W = 6,
  parameter int BYTES_W = 8,
  parameter int SCALE_SHIFT = 4
) (
  // Register bus
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire usage_monitor_pkg::space_t space,
  input wire logic [usage_monitor_pkg::ADDR_W-1:0] addr,
  input wire logic [usage_monitor_pkg::DATA_W-1:0] wdata,
  output logic [usage_monitor_pkg::DATA_W-1:0] rdata,
  output logic ack,
  // Per-space selection and scaling, feature straps
  input wire logic [3:0][usage_monitor_pkg::SEL_W-1:0] monitor_number_field,
  input wire logic [3:0][INST_W-1:0] resource_instance_field,
  input wire logic [3:0] scale_en,
  input wire logic overflow_bitmap_present,
  input wire logic monitoring_present,
  input wire logic bw_monitor_present,
  input wire logic instance_select_present,
  input wire logic four_space_extension,
  // Storage monitor wrap and software clear pulses
  input wire logic ovf_set,
  input wire usage_monitor_pkg::space_t ovf_set_space,
  input wire logic [INST_W-1:0] ovf_set_inst,
  input wire logic [usage_monitor_pkg::SEL_W-1:0] ovf_set_mon,
  input wire logic ovf_clear,
  input wire usage_monitor_pkg::space_t ovf_clear_space,
  input wire logic [INST_W-1:0] ovf_clear_inst,
  input wire logic [usage_monitor_pkg::SEL_W-1:0] ovf_clear_mon,
  // Transfer reports from the filter logic
  input wire logic xfer_valid,
  input wire logic xfer_match,
  input wire usage_monitor_pkg::space_t xfer_space,
  input wire logic [INST_W-1:0] xfer_inst,
  input wire logic [usage_monitor_pkg::SEL_W-1:0] xfer_mon,
  input wire logic [BYTES_W-1:0] xfer_bytes
);
  import usage_monitor_pkg::*;

  localparam int IDX_W = 2 + INST_W + MON_W;
  localparam int NUM_SLOT = 1 << IDX_W;
  localparam int NUM_MON = 1 << MON_W;
  localparam int CNT_W = VALUE_W + SCALE_SHIFT + 1;

  function automatic logic [IDX_W-1:0] slot(input space_t s, input logic [INST_W-1:0] r,
                                            input logic [SEL_W-1:0] m);
    return {s, r, m[MON_W-1:0]};
  endfunction : slot

  function automatic logic in_range(input logic [SEL_W-1:0] m);
    return (m >> MON_W) == '0;
  endfunction : in_range

  // Rounds half up before shifting out the low bits
  function automatic logic [VALUE_W-1:0] scaled(input logic [CNT_W-1:0] c, input logic en);
    logic [CNT_W-1:0] r;
    r = c;
    if (en && SCALE_SHIFT > 0) begin
      r = (c + (CNT_W'(1) << (SCALE_SHIFT - 1))) >> SCALE_SHIFT;
    end
    return r[VALUE_W-1:0];
  endfunction : scaled

  // Per space, instance and monitor state
  logic ovf_pend [NUM_SLOT];
  logic not_ready [NUM_SLOT];
  logic [CNT_W-1:0] cnt [NUM_SLOT];

  // Frame decode
  // Realm shares the root gating; both frames exist only with the extension
  wire space_ok = (space == SPACE_SECURE) || (space == SPACE_NONSECURE)
                  || four_space_extension;
  wire hit_ovf = req && space_ok && addr == OFF_OVF_BITMAP
                 && overflow_bitmap_present;
  wire bw_ok = monitoring_present && bw_monitor_present;
  wire hit_bw = req && space_ok && addr == OFF_BW_COUNT && bw_ok;
  wire [INST_W-1:0] acc_inst = instance_select_present ? resource_instance_field[space]
                                                       : '0;
  wire [SEL_W-1:0] acc_mon = monitor_number_field[space];
  wire [IDX_W-1:0] acc_idx = slot(space, acc_inst, acc_mon);
  wire acc_valid = in_range(acc_mon);
  wire bw_write = hit_bw && wr && acc_valid;
  wire [SEL_W-1:0] group_base = acc_mon & GROUP_MASK;

  // Overflow group word for the selected instance
  logic [GROUP_W-1:0] group_bits;
  always_comb begin
    logic [SEL_W-1:0] m;
    m = '0;
    group_bits = '0;
    for (int i = 0; i < GROUP_W; i++) begin
      m = group_base + SEL_W'(i);
      group_bits[i] = in_range(m) && ovf_pend[slot(space, acc_inst, m)];
    end
  end

  // Writes and refused reads still ack, with zero data
  wire [DATA_W-1:0] bw_word = {not_ready[acc_idx],
                               scaled(cnt[acc_idx], scale_en[space])};
  wire [DATA_W-1:0] read_word = (hit_ovf && !wr) ? group_bits
                              : (hit_bw && !wr && acc_valid) ? bw_word : '0;

  // Writes are held in the unscaled domain so a scaled read returns them
  wire [CNT_W-1:0] load_raw = scale_en[space] ? (CNT_W'(wdata[VALUE_W-1:0]) << SCALE_SHIFT)
                                              : CNT_W'(wdata[VALUE_W-1:0]);

  // Counting side; the instance field is ignored when selection is absent
  wire [IDX_W-1:0] xfer_idx = slot(xfer_space, instance_select_present ? xfer_inst : '0,
                                   xfer_mon);
  wire xfer_count = xfer_valid && xfer_match && in_range(xfer_mon) && bw_ok;
  wire [CNT_W-1:0] next_cnt = cnt[xfer_idx] + CNT_W'(xfer_bytes);
  wire [IDX_W-1:0] set_idx = slot(ovf_set_space, ovf_set_inst, ovf_set_mon);
  wire [IDX_W-1:0] clr_idx = slot(ovf_clear_space, ovf_clear_inst, ovf_clear_mon);

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= RESET_RDATA;
      ack <= 1'b0;
    end else begin
      ack <= req;
      rdata <= read_word;
    end
  end

  // Set beats clear so a wrap in the clearing cycle is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NUM_SLOT; k++) begin
        ovf_pend[k] <= RESET_OVF;
      end
    end else begin
      if (ovf_clear && in_range(ovf_clear_mon)) begin
        ovf_pend[clr_idx] <= 1'b0;
      end
      if (ovf_set && in_range(ovf_set_mon)) begin
        ovf_pend[set_idx] <= 1'b1;
      end
    end
  end

  // Counts reset to zero and are flagged not ready until software loads them
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < NUM_SLOT; k++) begin
        cnt[k] <= '0;
        not_ready[k] <= RESET_NOT_READY;
      end
    end else begin
      if (xfer_count) begin
        cnt[xfer_idx] <= next_cnt;
      end
      if (bw_write) begin
        cnt[acc_idx] <= load_raw;
        not_ready[acc_idx] <= 1'b0;
      end
    end
  end

  // Reference rounding for the scaled read check, kept apart from the read path
  wire [CNT_W-1:0] half_up = cnt[acc_idx] + CNT_W'(2 ** SCALE_SHIFT / 2);
  wire [VALUE_W-1:0] ref_scaled = VALUE_W'(half_up >> SCALE_SHIFT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ovf_read_s;
    req && !wr && addr == OFF_OVF_BITMAP;
  endsequence

  sequence count_read_s;
    req && !wr && addr == OFF_BW_COUNT;
  endsequence

  sequence write_req_s;
    req && wr;
  endsequence

  // Bus answer
  chk_ack_one_cycle: assert property (req |=> ack ##0 $past(req))
    else $error("ack did not follow request");

  chk_ack_quiet: assert property (!req |=> !ack)
    else $error("ack without request");

  chk_write_reads_zero: assert property (write_req_s |=> rdata == '0)
    else $error("write answered with data");

  // Refused accesses read zero
  chk_bitmap_read_only: assert property (
    write_req_s ##0 addr == OFF_OVF_BITMAP |=> ack && rdata == '0)
    else $error("bitmap write answered with data");

  chk_realm_frame_gone: assert property (
    req && space == SPACE_REALM && !four_space_extension |=> rdata == '0)
    else $error("realm frame answered without extension");

  chk_unmapped_zero: assert property (
    req && addr != OFF_OVF_BITMAP && addr != OFF_BW_COUNT |=> rdata == '0)
    else $error("unmapped offset read nonzero");

  chk_out_of_range_zero: assert property (
    count_read_s ##0 !acc_valid |=> rdata == '0)
    else $error("count read beyond monitors nonzero");

  chk_ovf_absent_zero: assert property (
    ovf_read_s ##0 !overflow_bitmap_present |=> rdata == '0)
    else $error("absent bitmap read nonzero");

  chk_bw_absent_zero: assert property (
    req && addr == OFF_BW_COUNT && !(monitoring_present && bw_monitor_present) |=> rdata == '0)
    else $error("absent count read nonzero");

  chk_root_frame_gone: assert property (
    req && space == SPACE_ROOT && !four_space_extension |=> rdata == '0)
    else $error("root frame answered without extension");

  // Overflow state
  chk_ovf_sticky_set: assert property (
    ovf_set && in_range(ovf_set_mon) |=> ovf_pend[$past(set_idx)])
    else $error("overflow pending not set");

  chk_ovf_clear_drops: assert property (
    ovf_clear && in_range(ovf_clear_mon) && !(ovf_set && set_idx == clr_idx)
    |=> !ovf_pend[$past(clr_idx)])
    else $error("overflow pending not cleared");

  chk_ovf_pending_holds: assert property (
    ovf_pend[acc_idx] && !(ovf_clear && in_range(ovf_clear_mon) && clr_idx == acc_idx)
    |=> ovf_pend[$past(acc_idx)])
    else $error("overflow pending lost");

  chk_ovf_group_read: assert property (
    ovf_read_s ##0 overflow_bitmap_present && space_ok |=> rdata == $past(group_bits))
    else $error("bitmap read mismatch");

  // Counter state
  chk_write_sets_ready: assert property (
    bw_write |=> !not_ready[$past(acc_idx)] ##1 1'b1)
    else $error("not ready left set after load");

  chk_ready_holds: assert property (
    !bw_write |=> not_ready[$past(acc_idx)] == $past(not_ready[acc_idx]))
    else $error("not ready changed without load");

  chk_unscaled_read: assert property (
    count_read_s ##0 bw_ok && space_ok && acc_valid && !scale_en[space]
    |=> rdata[VALUE_W-1:0] == $past(cnt[acc_idx][VALUE_W-1:0]))
    else $error("count value misreported");

  chk_scaled_read: assert property (
    count_read_s ##0 bw_ok && space_ok && acc_valid && scale_en[space]
    |=> rdata[VALUE_W-1:0] == $past(ref_scaled))
    else $error("scaled count misreported");

  chk_no_match_no_count: assert property (
    xfer_valid && !xfer_match && !bw_write |=> cnt[$past(xfer_idx)] == $past(cnt[xfer_idx]))
    else $error("unmatched transfer counted");

  chk_write_loads: assert property (
    bw_write && !scale_en[space] |=> cnt[$past(acc_idx)] == CNT_W'($past(wdata[VALUE_W-1:0])))
    else $error("count not loaded");

  chk_count_grows: assert property (
    xfer_count && !(bw_write && acc_idx == xfer_idx)
    |=> cnt[$past(xfer_idx)] == $past(next_cnt))
    else $error("count did not accumulate");

  chk_bw_read_flag: assert property (
    hit_bw && !wr && acc_valid |=> rdata[NOT_READY_POS] == $past(not_ready[acc_idx]))
    else $error("not ready flag misreported");

endmodule : usage_monitor_status_regs

// ===== verification/usage_monitor_status_regs_test.sv
/* Bench for usage_monitor_status_regs: register reads, writes and events.
   Assumes the package and design compiled first; one 20 MHz clock, default widths. */
`timescale 1ns/100ps
module usage_monitor_status_regs_test;
  import usage_monitor_pkg::*;
  localparam int SH = 4;
  logic clk, rst, req, wr, ack, ovf_set, ovf_clear, xfer_valid, xfer_match;
  logic ovf_bp, mon_p, bw_p, inst_p, ext;
  space_t space, set_sp, clr_sp, xf_sp;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0][15:0] mon_num;
  logic [3:0][0:0] inst_sel;
  logic [3:0] scale_en;
  logic [15:0] set_mon, clr_mon, xf_mon;
  logic [0:0] set_inst, clr_inst, xf_inst;
  logic [7:0] xf_bytes;
  int err_total, total_checks;
  usage_monitor_status_regs #(.INST_W(1), .MON_W(6), .BYTES_W(8), .SCALE_SHIFT(SH)) DUT (
    .clk(clk), .rst(rst), .req(req), .wr(wr), .space(space), .addr(addr), .wdata(wdata),
    .rdata(rdata), .ack(ack), .monitor_number_field(mon_num),
    .resource_instance_field(inst_sel), .scale_en(scale_en),
    .overflow_bitmap_present(ovf_bp), .monitoring_present(mon_p), .bw_monitor_present(bw_p),
    .instance_select_present(inst_p), .four_space_extension(ext), .ovf_set(ovf_set),
    .ovf_set_space(set_sp), .ovf_set_inst(set_inst), .ovf_set_mon(set_mon),
    .ovf_clear(ovf_clear), .ovf_clear_space(clr_sp), .ovf_clear_inst(clr_inst),
    .ovf_clear_mon(clr_mon), .xfer_valid(xfer_valid), .xfer_match(xfer_match),
    .xfer_space(xf_sp), .xfer_inst(xf_inst), .xfer_mon(xf_mon), .xfer_bytes(xf_bytes));
  task check(input logic [32:0] seen, input logic [32:0] exp, input logic [11:0] a);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error reg %h expected %h seen %h", a, exp, seen);
    end
  endtask : check
  // One access; ack and rdata are looked at in the single cycle they stand
  task acc(input logic w, input space_t s, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    #2 req = 1;
    wr = w;
    space = s;
    addr = a;
    wdata = 32'hffff_ffff;
    @(posedge clk);
    #2 req = 0;
    check({ack, rdata}, {1'b1, e}, a);
  endtask : acc
  task tick;
    @(posedge clk);
    #2;
  endtask : tick
  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    {req, wr, ovf_set, ovf_clear, xfer_valid, xfer_match, inst_p} = '0;
    {ovf_bp, mon_p, bw_p, ext, rst} = '1;
    {space, set_sp, clr_sp, xf_sp, addr, wdata, inst_sel, scale_en} = '0;
    {set_mon, clr_mon, xf_mon, set_inst, clr_inst, xf_inst, xf_bytes} = '0;
    mon_num = '0;
    repeat (6) @(posedge clk);
    #2 rst = 0;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h8000_0000);
    acc(1, SPACE_SECURE, OFF_BW_COUNT, 32'h0);
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h7fff_ffff);
    wdata = 32'h5;
    @(posedge clk);
    #2 {req, wr} = 2'b11;
    tick();
    req = 0;
    xf_bytes = 8'h10;
    {xfer_valid, xfer_match} = 2'b11;
    tick();
    xfer_match = 0;
    tick();
    xfer_valid = 0;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h15);
    scale_en[0] = 1;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, (32'h15 + (32'h1 << (SH - 1))) >> SH);
    scale_en[0] = 0;
    acc(0, SPACE_NONSECURE, OFF_BW_COUNT, 32'h8000_0000);
    inst_p = 1;
    inst_sel[0] = 1'b1;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h8000_0000);
    inst_p = 0;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h15);
    inst_sel = '0;
    mon_num[0] = 16'h0040;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h0);
    // Pending bit on monitor 33 of the non-secure space
    {set_sp, set_mon} = {SPACE_NONSECURE, 16'h0021};
    {clr_sp, clr_mon} = {SPACE_NONSECURE, 16'h0021};
    mon_num[1] = 16'h0021;
    mon_num[0] = 16'h0020;
    ovf_set = 1;
    tick();
    ovf_set = 0;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h2);
    acc(0, SPACE_SECURE, OFF_OVF_BITMAP, 32'h0);
    acc(1, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h0);
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h2);
    inst_p = 1;
    inst_sel[1] = 1'b1;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h0);
    inst_sel[1] = 1'b0;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h2);
    inst_p = 0;
    mon_num[1] = 16'h0000;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h0);
    mon_num[1] = 16'h0020;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h2);
    mon_num[1] = 16'h003f;
    ovf_bp = 0;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h0);
    ovf_bp = 1;
    ovf_clear = 1;
    tick();
    ovf_clear = 0;
    acc(0, SPACE_NONSECURE, OFF_OVF_BITMAP, 32'h0);
    acc(0, SPACE_ROOT, OFF_BW_COUNT, 32'h8000_0000);
    ext = 0;
    acc(0, SPACE_ROOT, OFF_BW_COUNT, 32'h0);
    acc(0, SPACE_REALM, OFF_OVF_BITMAP, 32'h0);
    ext = 1;
    mon_p = 0;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h0);
    mon_p = 1;
    bw_p = 0;
    acc(0, SPACE_SECURE, OFF_BW_COUNT, 32'h0);
    bw_p = 1;
    acc(0, SPACE_SECURE, 12'h864, 32'h0);
    results();
  end
endmodule : usage_monitor_status_regs_test
